// >>> design/ssl_supervisor.sv
// supply supervisor top: synchronisation, fault latch, start and power-good outputs
//
// Chosen here: the plain strobed port and the register offsets.
module ssl_supervisor
   import ssl_pkg::*;
#(
   parameter ssl_opt_t OPTION = SSL_OPT_A
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_supply_enable_in,
   input  wire logic             i_supply_lockout,
   input  wire logic [LVL_W-1:0] i_range_bottom,
   input  wire logic [LVL_W-1:0] i_range_top,
   input  wire logic [SEL_W-1:0] i_level_select_bits,
   input  wire logic [LVL_W-1:0] i_threshold_level_in,
   input  wire logic [LVL_W-1:0] i_monitored_level_in,
   input  wire logic [1:0]       i_reg_addr,
   input  wire logic [31:0]      i_reg_wdata,
   input  wire logic             i_reg_wr,
   input  wire logic             i_reg_rd,
   output logic [31:0]           o_reg_rdata,
   output logic                  o_irq,
   output logic                  o_start_out,
   output logic                  o_start_oe,
   output logic                  o_power_good_out,
   output logic                  o_power_good_oe
);
   localparam logic HAS_LATCH = (OPTION != SSL_OPT_B);
   localparam int   HYS_PCT   = (OPTION == SSL_OPT_B) ? HYS_B_PCT : HYS_AC_PCT;

   // two-stage synchronisers on the control levels
   logic [1:0] en_sync;
   logic [1:0] lock_sync;
   logic       en_s;
   logic       lock_s;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_sync   <= 2'b00;
         lock_sync <= 2'b11;
      end else begin
         en_sync   <= {en_sync[0], i_supply_enable_in};
         lock_sync <= {lock_sync[0], i_supply_lockout};
      end
   end
   assign en_s   = en_sync[1];
   assign lock_s = lock_sync[1];

   logic             uv;
   logic             ov;
   logic             delayed_undervoltage_flag;
   logic [DLY_W-1:0] undervoltage_delay;

   ssl_window #(
      .HYS_PCT (HYS_PCT)
   ) u_window (
      .i_core_clk           (i_core_clk),
      .i_rst_n              (i_rst_n),
      .i_range_bottom       (i_range_bottom),
      .i_range_top          (i_range_top),
      .i_level_select_bits  (i_level_select_bits),
      .i_threshold_level_in (i_threshold_level_in),
      .i_monitored_level_in (i_monitored_level_in),
      .o_uv                 (uv),
      .o_ov                 (ov)
   );

   ssl_delay u_delay (
      .i_core_clk                  (i_core_clk),
      .i_rst_n                     (i_rst_n),
      .i_uv                        (uv),
      .i_undervoltage_delay        (undervoltage_delay),
      .o_delayed_undervoltage_flag (delayed_undervoltage_flag)
   );

   // fault latch
   logic fault;
   wire  no_fault    = !ov && !delayed_undervoltage_flag;
   wire  clr_event   = lock_s || ((OPTION == SSL_OPT_C) && !en_s);
   wire  fault_set   = HAS_LATCH && (ov || delayed_undervoltage_flag);
   wire  fault_clr   = no_fault && clr_event;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fault <= 1'b0;
      end else if (fault_set) begin
         fault <= 1'b1;
      end else if (fault_clr) begin
         fault <= 1'b0;
      end
   end

   // output terms per option
   wire start_base = en_s && !lock_s;
   wire start_b    = !ov && !delayed_undervoltage_flag;
   wire next_start = start_base && (HAS_LATCH ? !fault : start_b);
   wire pg_base    = !lock_s && !uv;
   wire pg_ov      = (OPTION == SSL_OPT_A) || !ov;
   wire pg_en      = (OPTION == SSL_OPT_C) || en_s;
   wire pg_flt     = (OPTION != SSL_OPT_A) || !fault;
   wire next_pg    = pg_base && pg_ov && pg_en && pg_flt;

   logic start_q;
   logic pg_q;
   // lockout gates these two outputs and clears a fault-free latch; comparators keep running
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_q <= 1'b0;
         pg_q    <= 1'b0;
      end else begin
         start_q <= next_start;
         pg_q    <= next_pg;
      end
   end

   // open drain: pin low means the pull-up is overridden, so drive only when deasserted
   assign o_start_out      = 1'b0;
   assign o_start_oe       = !start_q;
   assign o_power_good_out = 1'b0;
   assign o_power_good_oe  = !pg_q;

   // register file: sticky status, mask, delay count, live view
   logic [IRQ_W-1:0] status;
   logic [IRQ_W-1:0] mask;
   logic             fault_d;
   logic             uvd_d;
   logic             ov_d;
   wire  [IRQ_W-1:0] events;
   wire              wr_stat = i_reg_wr && (i_reg_addr == ADR_STAT);
   wire              wr_mask = i_reg_wr && (i_reg_addr == ADR_MASK);
   wire              wr_dly  = i_reg_wr && (i_reg_addr == ADR_DLY);
   wire  [IRQ_W-1:0] w1c     = wr_stat ? i_reg_wdata[IRQ_W-1:0] : '0;
   wire  [31:0]      live    = {26'h0, start_q, pg_q, fault, delayed_undervoltage_flag, ov, uv};
   wire  [31:0]      rd_mux  = (i_reg_addr == ADR_STAT) ? {29'h0, status} :
                               (i_reg_addr == ADR_MASK) ? {29'h0, mask} :
                               (i_reg_addr == ADR_DLY)  ? {8'h0, undervoltage_delay} : live;

   assign events[IRQ_OV]  = ov && !ov_d;
   assign events[IRQ_UVD] = delayed_undervoltage_flag && !uvd_d;
   assign events[IRQ_FLT] = fault && !fault_d;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ov_d    <= 1'b0;
         uvd_d   <= 1'b0;
         fault_d <= 1'b0;
         status  <= '0;
      end else begin
         ov_d    <= ov;
         uvd_d   <= delayed_undervoltage_flag;
         fault_d <= fault;
         // a new event wins over a simultaneous clear
         status  <= (status & ~w1c) | events;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mask               <= '0;
         undervoltage_delay <= DLY_RST;
         o_reg_rdata        <= '0;
      end else begin
         if (wr_mask) begin
            mask <= i_reg_wdata[IRQ_W-1:0];
         end
         if (wr_dly) begin
            undervoltage_delay <= i_reg_wdata[DLY_W-1:0];
         end
         o_reg_rdata <= i_reg_rd ? rd_mux : '0;
      end
   end

   assign o_irq = |(status & mask);

   start_cause_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      start_q |-> $past(en_s) && !$past(lock_s))
      else $error("start asserted without enable or during lockout");
   start_b_fault_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (OPTION == SSL_OPT_B) && (ov || delayed_undervoltage_flag) |=> !start_q)
      else $error("option B start asserted during fault");
   start_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      HAS_LATCH && fault |=> !start_q)
      else $error("start asserted with fault latched");
   pg_cause_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      pg_q |-> !$past(lock_s) && !$past(uv))
      else $error("power-good asserted during lockout or undervoltage");
   pg_option_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      pg_q |-> ($past(pg_ov) && $past(pg_en)))
      else $error("power-good option terms violated");
   pg_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (OPTION == SSL_OPT_A) && fault |=> !pg_q)
      else $error("option A power-good with fault latched");
   latch_set_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      HAS_LATCH && (ov || delayed_undervoltage_flag) |=> fault)
      else $error("fault latch did not set");
   latch_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $fell(fault) |-> $past(no_fault) && $past(clr_event))
      else $error("fault latch cleared without cause");
   no_latch_b_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (OPTION == SSL_OPT_B) |-> !fault)
      else $error("option B latched a fault");
   irq_level_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      events[IRQ_FLT] && mask[IRQ_FLT] && !wr_mask |=> o_irq)
      else $error("masked-in fault event missed the interrupt");

   start_seen_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(start_q));
   fault_seen_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(fault));
   recover_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $fell(fault));
   uvd_seen_c: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(delayed_undervoltage_flag));
endmodule : ssl_supervisor

// >>> design/ssl_pkg.sv
// constants and types shared by the supply supervisor logic
// What this block does
// - start needs supply enable high and supply above lockout, every option
// - option B start also needs no overvoltage and no delayed undervoltage
// - options A and C start also needs fault latch clear
// - power-good needs supply above lockout and no undervoltage, every option
// - power-good needs no overvoltage in B and C, supply enable in A and B
// - option A power-good also needs fault latch clear
// - fault latch in A and C sets on overvoltage or delayed undervoltage
// - latch clears without faults on lockout, or in C also on low supply enable
// - option B has no latch; outputs follow faults and self-recover
// - undervoltage below threshold level; overvoltage above mirrored level
// - hysteresis is 10 percent of reference minus threshold level in A and C, 40 percent in B
// - delayed flag rises only if undervoltage lasts until the delay ends
// - lockout gates start and power-good outputs and clears the latch when no fault
// - reference is range bottom plus select code times span over 31
package ssl_pkg;
   localparam int LVL_W = 12;
   localparam int SEL_W = 5;
   localparam int DLY_W = 24;
   localparam logic [SEL_W-1:0] SEL_STEPS = 5'h1F;
   localparam int HYS_AC_PCT = 10;
   localparam int HYS_B_PCT = 40;
   localparam int PCT_FULL = 100;
   localparam real CLK_MHZ = 40.0;
   localparam real DLY_DEF_US = 25.0;
   localparam int DLY_DEF_CYC = int'(DLY_DEF_US * CLK_MHZ);
   localparam logic [DLY_W-1:0] DLY_RST = DLY_W'(DLY_DEF_CYC);
   typedef enum {SSL_OPT_A, SSL_OPT_B, SSL_OPT_C} ssl_opt_t;
   localparam int IRQ_W = 3;
   localparam int IRQ_OV = 0;
   localparam int IRQ_UVD = 1;
   localparam int IRQ_FLT = 2;
   localparam logic [1:0] ADR_STAT = 2'h0;
   localparam logic [1:0] ADR_MASK = 2'h1;
   localparam logic [1:0] ADR_DLY = 2'h2;
   localparam logic [1:0] ADR_LIVE = 2'h3;
endpackage : ssl_pkg

// >>> design/ssl_window.sv
// window comparator with hysteresis and reference from select code
module ssl_window
   import ssl_pkg::*;
#(
   parameter int HYS_PCT = HYS_AC_PCT
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_n,
   input  wire logic [LVL_W-1:0] i_range_bottom,
   input  wire logic [LVL_W-1:0] i_range_top,
   input  wire logic [SEL_W-1:0] i_level_select_bits,
   input  wire logic [LVL_W-1:0] i_threshold_level_in,
   input  wire logic [LVL_W-1:0] i_monitored_level_in,
   output logic                  o_uv,
   output logic                  o_ov
);
   logic [LVL_W+SEL_W-1:0] span_x;
   logic [LVL_W+1:0]       ref_lvl;
   logic [LVL_W+1:0]       delta;
   logic [LVL_W+1:0]       hys;
   logic [LVL_W+1:0]       mon;
   logic [LVL_W+1:0]       ov_trip;
   logic                   next_uv;
   logic                   next_ov;

   // reference in steps of span/31, computed as product then divide to keep precision
   assign span_x  = (LVL_W+SEL_W)'(i_range_top - i_range_bottom) * (LVL_W+SEL_W)'(i_level_select_bits);
   assign ref_lvl = (LVL_W+2)'(i_range_bottom) + (LVL_W+2)'(span_x / (LVL_W+SEL_W)'(SEL_STEPS));
   assign delta   = (ref_lvl > (LVL_W+2)'(i_threshold_level_in)) ?
                    ref_lvl - (LVL_W+2)'(i_threshold_level_in) : '0;
   assign hys     = (LVL_W+2)'((32'(delta) * HYS_PCT) / PCT_FULL);
   assign mon     = (LVL_W+2)'(i_monitored_level_in);
   assign ov_trip = ref_lvl + delta;
   // trip at threshold, release only after crossing back by the hysteresis band
   assign next_uv = o_uv ? (mon < (LVL_W+2)'(i_threshold_level_in) + hys)
                         : (mon < (LVL_W+2)'(i_threshold_level_in));
   assign next_ov = o_ov ? (mon + hys > ov_trip) : (mon > ov_trip);

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_uv <= 1'b0;
         o_ov <= 1'b0;
      end else begin
         o_uv <= next_uv;
         o_ov <= next_ov;
      end
   end
endmodule : ssl_window

// >>> design/ssl_delay.sv
// undervoltage delay timer producing the delayed undervoltage flag
module ssl_delay
   import ssl_pkg::*;
(
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_uv,
   input  wire logic [DLY_W-1:0] i_undervoltage_delay,
   output logic                  o_delayed_undervoltage_flag
);
   logic [DLY_W-1:0] count;
   wire              expired = (count >= i_undervoltage_delay);

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count <= '0;
      end else if (!i_uv) begin
         count <= '0;
      end else if (!expired) begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_delayed_undervoltage_flag <= 1'b0;
      end else begin
         o_delayed_undervoltage_flag <= i_uv && expired;
      end
   end

   uvd_after_delay_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $rose(o_delayed_undervoltage_flag) |-> $past(i_uv) && $past(expired))
      else $error("delayed flag rose before delay expired");
   uvd_restart_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !i_uv |=> count == '0 && !o_delayed_undervoltage_flag)
      else $error("delay did not restart when undervoltage cleared");
endmodule : ssl_delay

// >>> sim/ssl_conv_model.sv
// converter-side model: pull-ups on the open-drain start and power-good pins of each option
module ssl_conv_model
(
   input  wire logic [2:0] i_start_out,
   input  wire logic [2:0] i_start_oe,
   input  wire logic [2:0] i_power_good_out,
   input  wire logic [2:0] i_power_good_oe,
   output logic      [2:0] o_start_pin,
   output logic      [2:0] o_power_good_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // a released pin rises through the pull-up; the converter reads high as asserted
   assign o_start_pin      = (i_start_oe & i_start_out) | ~i_start_oe;
   assign o_power_good_pin = (i_power_good_oe & i_power_good_out) | ~i_power_good_oe;
endmodule : ssl_conv_model

// >>> sim/tb_top.sv
// testbench: options A, B and C side by side on one stimulus and one register bus
module tb_top
   import ssl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clk;
   logic             rst_n;
   logic             en;
   logic             lock;
   logic [SEL_W-1:0] sel;
   logic [LVL_W-1:0] lvl;
   logic [1:0]       addr;
   logic [31:0]      wdata;
   logic             wr;
   logic             rd;
   logic [31:0]      rdata [3];
   logic [31:0]      rv [3];
   logic [2:0]       irq;
   logic [2:0]       s_out;
   logic [2:0]       s_oe;
   logic [2:0]       p_out;
   logic [2:0]       p_oe;
   logic [2:0]       start_pin;
   logic [2:0]       pg_pin;
   int               miscompares;
   int               tests_run;

   // bit 0 of every vector is option A, bit 1 option B, bit 2 option C
   for (genvar g = 0; g < 3; g++) begin : opt
      ssl_supervisor #(.OPTION(ssl_opt_t'(g))) ssl_supervisor_i (
         .i_core_clk(clk), .i_rst_n(rst_n), .i_supply_enable_in(en), .i_supply_lockout(lock),
         .i_range_bottom(12'h100), .i_range_top(12'h4E0), .i_level_select_bits(sel),
         .i_threshold_level_in(12'h280), .i_monitored_level_in(lvl), .i_reg_addr(addr),
         .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata[g]), .o_irq(irq[g]),
         .o_start_out(s_out[g]), .o_start_oe(s_oe[g]), .o_power_good_out(p_out[g]),
         .o_power_good_oe(p_oe[g]));
   end

   ssl_conv_model ssl_conv_model_i (
      .i_start_out(s_out), .i_start_oe(s_oe), .i_power_good_out(p_out), .i_power_good_oe(p_oe),
      .o_start_pin(start_pin), .o_power_good_pin(pg_pin));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic pins(input logic [2:0] es, input logic [2:0] ep);
      check({29'h0, start_pin}, {29'h0, es});
      check({29'h0, pg_pin}, {29'h0, ep});
   endtask : pins

   task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : reg_wr

   task automatic live_ov(input logic [1:0] a = 2'h3);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      rv = rdata;
   endtask : live_ov

   task automatic level(input logic [LVL_W-1:0] v);
      @(posedge clk);
      lvl <= v;
   endtask : level

   // long enough for sync, comparator, delay of 4, latch and output register
   task automatic settle();
      repeat (12) @(posedge clk);
      #1;
   endtask : settle

   task automatic t_nominal();
      reg_wr(2'h2, 32'h0000_0004);
      reg_wr(2'h1, 32'h0000_0005);
      settle();
      pins(3'h7, 3'h7);
      live_ov(2'h2);
      check(rv[0], 32'h0000_0004);
      check({29'h0, irq}, 32'h0);
      $display("test nominal done");
   endtask : t_nominal

   task automatic t_overvoltage();
      level(12'h390);
      settle();
      pins(3'h0, 3'h0);
      check({29'h0, irq}, 32'h7);
      live_ov(2'h0);
      check(rv[0], 32'h0000_0005);
      check(rv[1], 32'h0000_0001);
      check(rv[2], 32'h0000_0005);
      level(12'h360);
      settle();
      live_ov();
      check({29'h0, rv[2][1], rv[1][1], rv[0][1]}, 32'h2);
      level(12'h300);
      settle();
      pins(3'h2, 3'h6);
      reg_wr(2'h0, 32'h0000_0007);
      settle();
      check({29'h0, irq}, 32'h0);
      $display("test overvoltage done");
   endtask : t_overvoltage

   task automatic t_enable();
      @(posedge clk);
      en <= 1'b0;
      settle();
      pins(3'h0, 3'h4);
      @(posedge clk);
      en <= 1'b1;
      settle();
      pins(3'h6, 3'h6);
      $display("test enable done");
   endtask : t_enable

   task automatic t_lockout();
      @(posedge clk);
      lock <= 1'b1;
      settle();
      pins(3'h0, 3'h0);
      @(posedge clk);
      lock <= 1'b0;
      settle();
      pins(3'h7, 3'h7);
      $display("test lockout done");
   endtask : t_lockout

   task automatic t_undervoltage();
      level(12'h260);
      repeat (2) @(posedge clk);
      lvl <= 12'h300;
      settle();
      pins(3'h7, 3'h7);
      level(12'h260);
      settle();
      pins(3'h0, 3'h0);
      level(12'h300);
      settle();
      pins(3'h2, 3'h6);
      $display("test undervoltage done");
   endtask : t_undervoltage

   task automatic t_ref_select();
      @(posedge clk);
      // code 19 puts the reference at 0x360, so the mirrored trip sits exactly at 0x440
      sel <= 5'h13;
      lvl <= 12'h440;
      settle();
      live_ov();
      check({29'h0, rv[2][1], rv[1][1], rv[0][1]}, 32'h0);
      level(12'h441);
      settle();
      live_ov();
      check({29'h0, rv[2][1], rv[1][1], rv[0][1]}, 32'h7);
      $display("test ref_select done");
   endtask : t_ref_select

   task automatic complete_run();
      $display("counts: %0d compared, %0d mismatched", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      complete_run();
   end

   initial begin
      miscompares = 0;
      tests_run   = 0;
      rst_n = 1'b0;
      en    = 1'b1;
      lock  = 1'b0;
      sel   = 5'h10;
      lvl   = 12'h300;
      addr  = 2'h0;
      wdata = 32'h0;
      wr    = 1'b0;
      rd    = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_nominal();
      t_overvoltage();
      t_enable();
      t_lockout();
      t_undervoltage();
      t_ref_select();
      complete_run();
   end
endmodule : tb_top
